// *** hw/cca_consts.svh ***
// constants for the counter array: sfr map, field positions, reset values, timing
`ifndef CCA_CONSTS_SVH
`define CCA_CONSTS_SVH
// device sfr addresses
`define CCA_SFR_CTRL    8'hd8
`define CCA_SFR_MODE    8'hd9
`define CCA_SFR_MMODE0  8'hda
`define CCA_SFR_CNT_LO  8'he9
`define CCA_SFR_CMPLO0  8'hea
`define CCA_SFR_CNT_HI  8'hf9
`define CCA_SFR_CMPHI0  8'hfa
// array_control_reg bits
`define CCA_CTRL_OVF    7
`define CCA_CTRL_RUN    6
// array_mode_reg bits
`define CCA_MODE_IDLE   7
`define CCA_MODE_SEL_HI 2
`define CCA_MODE_SEL_LO 1
`define CCA_MODE_OVF_IE 0
// module_mode_reg bits
`define CCA_MM_CMP_EN   6
`define CCA_MM_RISE     5
`define CCA_MM_FALL     4
`define CCA_MM_MATCH    3
`define CCA_MM_TOGGLE   2
`define CCA_MM_PWM      1
`define CCA_MM_IRQ_EN   0
// timebase codes
`define CCA_TB_SLOW     2'b00
`define CCA_TB_FAST     2'b01
`define CCA_TB_TMR0     2'b10
`define CCA_TB_EXT      2'b11
// timebase dividers in system clocks
`define CCA_DIV_SLOW    12
`define CCA_DIV_FAST    4
`define CCA_RST_BYTE    8'h00
// host apb map and control fields
`define CCA_APB_CTRL    12'h000
`define CCA_APB_STAT    12'h004
`define CCA_HC_WDATA    8
`define CCA_HC_GO_WR    16
`define CCA_HC_GO_RD    17
`define CCA_HC_GEN      24
`define CCA_HC_GRP      25
`define CCA_HC_IDLE     26
`endif

// *** hw/cca_pkg.sv ***
// types shared by both ends of the counter array
`default_nettype none
package cca_pkg;
   // module operating modes, one-hot
   typedef enum logic [4:0] {
      CCA_M_NONE = 5'h01,
      CCA_M_CAP  = 5'h02,
      CCA_M_TMR  = 5'h04,
      CCA_M_HSO  = 5'h08,
      CCA_M_PWM  = 5'h10
   } cca_mode_t;

   // complete state of the device end
   typedef struct packed {
      logic [15:0]      cnt;       // counter
      logic [7:0]       hi_latch;  // high byte caught by low read
      logic [3:0]       pre;       // prescaler
      logic [1:0]       ext_s;     // external count synchroniser
      logic             ext_p;     // previous synced level
      logic [4:0]       pin_s1;    // pin synchroniser stage 1
      logic [4:0]       pin_s2;    // pin synchroniser stage 2
      logic [4:0]       pin_p;     // previous synced pin
      logic             ovf;       // overflow_flag
      logic             run;       // counter_run
      logic             idle_susp; // idle_suspend_select
      logic [1:0]       sel;       // timebase select
      logic             ovf_ie;    // overflow_irq_enable
      logic [4:0]       flag;      // module_event_flag
      logic [4:0][7:0]  mmode;     // module_mode_reg
      logic [4:0][15:0] cmp;       // compare pair
      logic [4:0]       pin_out;   // pin levels
      logic [4:0]       pin_oe;    // pin enables
      logic [7:0]       rdata;     // sfr read data
      logic             rvalid;    // read answer strobe
      logic             irq;       // gated request
   } cca_dev_t;

   // complete state of the host end
   typedef struct packed {
      logic [7:0]  addr;   // sfr address of next order
      logic [7:0]  wdata;  // sfr write data
      logic        gen;    // global_interrupt_enable
      logic        grp;    // array_group_irq_enable
      logic        idle;   // core idle
      logic        wr;     // sfr write pulse
      logic        rd;     // sfr read pulse
      logic        busy;   // read in flight
      logic [7:0]  rbyte;  // last byte read
      logic        ack;    // apb answer ready
      logic [31:0] prdata; // apb read data
      logic        perr;   // apb error
   } cca_host_t;
endpackage
`default_nettype wire

// *** hw/cca_if.sv ***
// link between the cpu side and the counter array
`timescale 1ns/1ps
`default_nettype none
interface cca_if;
   logic [7:0] sfr_addr;  // register address
   logic [7:0] sfr_wdata; // write data
   logic       sfr_wr;    // write strobe
   logic       sfr_rd;    // read strobe
   logic [7:0] sfr_rdata; // read data
   logic       sfr_rvalid;// read answer
   logic       irq;       // interrupt request
   logic       gen;       // global_interrupt_enable
   logic       grp;       // array_group_irq_enable
   logic       core_idle; // cpu core in idle

   modport dev (input sfr_addr, sfr_wdata, sfr_wr, sfr_rd, gen, grp, core_idle,
                output sfr_rdata, sfr_rvalid, irq);
   modport cpu (output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, gen, grp, core_idle,
                input sfr_rdata, sfr_rvalid, irq);
endinterface
`default_nettype wire

// *** hw/cca_device.sv ***
// counter array: counter, timebase and five capture/compare modules
`include "cca_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cca_device (
   input  wire logic       i_clock,
   input  wire logic       i_rst_n,
   cca_if.dev              bus,
   input  wire logic       i_external_count_input,
   input  wire logic       i_timer0_ovf,
   input  wire logic [4:0] i_module_pin,
   output logic      [4:0] o_module_pin,
   output logic      [4:0] o_module_pin_oe
);
   localparam int NMOD = 5;

   cca_pkg::cca_dev_t s_r;   // current state
   cca_pkg::cca_dev_t s_nxt; // next state

   // mode byte to operating mode; anything unlisted is inert
   function automatic cca_pkg::cca_mode_t mode_of(input logic [7:0] m);
      logic cmp_en;
      logic r_en;
      logic f_en;
      logic match;
      logic toggle;
      logic pwm;
      cmp_en = m[`CCA_MM_CMP_EN];
      r_en   = m[`CCA_MM_RISE];
      f_en   = m[`CCA_MM_FALL];
      match  = m[`CCA_MM_MATCH];
      toggle = m[`CCA_MM_TOGGLE];
      pwm    = m[`CCA_MM_PWM];
      if ((r_en | f_en) && !match && !toggle && !pwm) begin
         mode_of = cca_pkg::CCA_M_CAP;
      end else if (cmp_en && !r_en && !f_en && match && !toggle && !pwm) begin
         mode_of = cca_pkg::CCA_M_TMR;
      end else if (cmp_en && !r_en && !f_en && match && toggle && !pwm) begin
         mode_of = cca_pkg::CCA_M_HSO;
      end else if (cmp_en && !r_en && !f_en && !toggle && pwm) begin
         mode_of = cca_pkg::CCA_M_PWM; // match bit ignored here
      end else begin
         mode_of = cca_pkg::CCA_M_NONE;
      end
   endfunction

   logic        tick;     // selected timebase event
   logic        adv;      // counter advances this cycle
   logic [15:0] nc;       // counter value after advance
   logic        ext_fall; // synced external falling edge
   logic [3:0]  pre_inc;  // prescaler plus one

   // next-state logic for the whole block
   always_comb begin
      cca_pkg::cca_mode_t md;
      logic rise;
      logic fall;
      logic hit;
      md    = cca_pkg::CCA_M_NONE;
      rise  = 1'b0;
      fall  = 1'b0;
      hit   = 1'b0;
      s_nxt = s_r;
      s_nxt.rvalid = 1'b0;

      // synchronisers; stage 1 feeds stage 2 only
      s_nxt.ext_s  = {s_r.ext_s[0], i_external_count_input};
      s_nxt.ext_p  = s_r.ext_s[1];
      s_nxt.pin_s1 = i_module_pin;
      s_nxt.pin_s2 = s_r.pin_s1;
      s_nxt.pin_p  = s_r.pin_s2;
      ext_fall     = s_r.ext_p & ~s_r.ext_s[1];

      // prescaler runs freely so timebase phase is independent of run
      pre_inc = s_r.pre + 4'h1;
      s_nxt.pre = (pre_inc == 4'(`CCA_DIV_SLOW)) ? 4'h0 : pre_inc;
      case (s_r.sel)
         `CCA_TB_SLOW: tick = (pre_inc == 4'(`CCA_DIV_SLOW));
         `CCA_TB_FAST: tick = (pre_inc[1:0] == 2'(`CCA_DIV_FAST));
         `CCA_TB_TMR0: tick = i_timer0_ovf;
         default:      tick = ext_fall;
      endcase
      // idle stops the count only when idle suspend is selected
      adv = tick & s_r.run & ~(s_r.idle_susp & bus.core_idle);
      nc  = s_r.cnt + 16'h0001;
      if (adv) begin
         s_nxt.cnt = nc;
      end

      // sfr writes; hardware events below override clears
      if (bus.sfr_wr) begin
         if (bus.sfr_addr == `CCA_SFR_CTRL) begin
            s_nxt.ovf  = bus.sfr_wdata[`CCA_CTRL_OVF];
            s_nxt.run  = bus.sfr_wdata[`CCA_CTRL_RUN];
            s_nxt.flag = bus.sfr_wdata[4:0];
         end else if (bus.sfr_addr == `CCA_SFR_MODE) begin
            s_nxt.idle_susp = bus.sfr_wdata[`CCA_MODE_IDLE];
            s_nxt.sel = bus.sfr_wdata[`CCA_MODE_SEL_HI:`CCA_MODE_SEL_LO];
            s_nxt.ovf_ie = bus.sfr_wdata[`CCA_MODE_OVF_IE];
         end else if (bus.sfr_addr == `CCA_SFR_CNT_LO) begin
            s_nxt.cnt[7:0] = bus.sfr_wdata;
         end else if (bus.sfr_addr == `CCA_SFR_CNT_HI) begin
            s_nxt.cnt[15:8] = bus.sfr_wdata;
         end else begin
            for (int i = 0; i < NMOD; i++) begin
               if (bus.sfr_addr == `CCA_SFR_MMODE0 + 8'(i)) begin
                  s_nxt.mmode[i] = bus.sfr_wdata;
               end else if (bus.sfr_addr == `CCA_SFR_CMPLO0 + 8'(i)) begin
                  s_nxt.cmp[i][7:0] = bus.sfr_wdata;
               end else if (bus.sfr_addr == `CCA_SFR_CMPHI0 + 8'(i)) begin
                  s_nxt.cmp[i][15:8] = bus.sfr_wdata;
               end
            end
         end
      end

      // sfr reads; the counter itself is only looked at, never touched
      if (bus.sfr_rd) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata  = `CCA_RST_BYTE;
         if (bus.sfr_addr == `CCA_SFR_CTRL) begin
            s_nxt.rdata = {s_r.ovf, s_r.run, 1'b0, s_r.flag};
         end else if (bus.sfr_addr == `CCA_SFR_MODE) begin
            s_nxt.rdata = {s_r.idle_susp, 4'h0, s_r.sel, s_r.ovf_ie};
         end else if (bus.sfr_addr == `CCA_SFR_CNT_LO) begin
            s_nxt.rdata    = s_r.cnt[7:0];
            s_nxt.hi_latch = s_r.cnt[15:8];
         end else if (bus.sfr_addr == `CCA_SFR_CNT_HI) begin
            s_nxt.rdata = s_r.hi_latch;
         end else begin
            for (int i = 0; i < NMOD; i++) begin
               if (bus.sfr_addr == `CCA_SFR_MMODE0 + 8'(i)) begin
                  s_nxt.rdata = s_r.mmode[i];
               end else if (bus.sfr_addr == `CCA_SFR_CMPLO0 + 8'(i)) begin
                  s_nxt.rdata = s_r.cmp[i][7:0];
               end else if (bus.sfr_addr == `CCA_SFR_CMPHI0 + 8'(i)) begin
                  s_nxt.rdata = s_r.cmp[i][15:8];
               end
            end
         end
      end

      // overflow flag: set wins over a same-cycle clear
      if (adv && s_r.cnt == 16'hffff) begin
         s_nxt.ovf = 1'b1;
      end

      // modules, each on its own mode
      for (int i = 0; i < NMOD; i++) begin
         md   = mode_of(s_r.mmode[i]);
         rise = s_r.pin_s2[i] & ~s_r.pin_p[i];
         fall = ~s_r.pin_s2[i] & s_r.pin_p[i];
         // matches are judged on the value just reached, so a stalled
         // counter cannot toggle a pin over and over
         hit  = adv && (nc == s_r.cmp[i]);
         s_nxt.pin_oe[i] = (mode_of(s_nxt.mmode[i]) == cca_pkg::CCA_M_HSO) ||
                           (mode_of(s_nxt.mmode[i]) == cca_pkg::CCA_M_PWM);
         case (md)
            cca_pkg::CCA_M_CAP: begin
               if ((rise && s_r.mmode[i][`CCA_MM_RISE]) ||
                   (fall && s_r.mmode[i][`CCA_MM_FALL])) begin
                  s_nxt.cmp[i]  = s_r.cnt;
                  s_nxt.flag[i] = 1'b1;
               end
            end
            cca_pkg::CCA_M_TMR: begin
               if (hit) begin
                  s_nxt.flag[i] = 1'b1;
               end
            end
            cca_pkg::CCA_M_HSO: begin
               if (hit) begin
                  s_nxt.pin_out[i] = ~s_r.pin_out[i];
                  s_nxt.flag[i]    = 1'b1;
               end
            end
            cca_pkg::CCA_M_PWM: begin
               if (adv && s_r.cnt[7:0] == 8'hff) begin
                  s_nxt.pin_out[i]  = 1'b0;
                  s_nxt.cmp[i][7:0] = s_r.cmp[i][15:8];
               end
               // equal low bytes win over the wrap when both fall together
               if (adv && nc[7:0] == s_r.cmp[i][7:0]) begin
                  s_nxt.pin_out[i] = 1'b1;
               end
            end
            default: begin
               s_nxt.pin_out[i] = s_r.pin_out[i];
            end
         endcase
      end

      // request only when both cpu enables allow it
      s_nxt.irq = bus.gen & bus.grp &
                  ((s_r.ovf & s_r.ovf_ie) |
                   (|(s_r.flag & {s_r.mmode[4][`CCA_MM_IRQ_EN], s_r.mmode[3][`CCA_MM_IRQ_EN],
                                  s_r.mmode[2][`CCA_MM_IRQ_EN], s_r.mmode[1][`CCA_MM_IRQ_EN],
                                  s_r.mmode[0][`CCA_MM_IRQ_EN]})));
   end

   // single state register
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus.sfr_rdata   = s_r.rdata;
   assign bus.sfr_rvalid  = s_r.rvalid;
   assign bus.irq         = s_r.irq;
   assign o_module_pin    = s_r.pin_out;
   assign o_module_pin_oe = s_r.pin_oe;
endmodule // cca_device
`default_nettype wire

// *** hw/cca_host.sv ***
// cpu side of the counter array: apb slave turning orders into sfr cycles
`include "cca_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cca_host (
   input  wire logic        i_clock,
   input  wire logic        i_rst_n,
   cca_if.cpu               bus,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);
   cca_pkg::cca_host_t s_r;   // current state
   cca_pkg::cca_host_t s_nxt; // next state

   logic take; // apb access completes this edge
   logic ctrl; // address hits control
   logic stat; // address hits status

   // next-state logic
   always_comb begin
      s_nxt    = s_r;
      s_nxt.wr = 1'b0;
      s_nxt.rd = 1'b0;
      ctrl = (paddr == `CCA_APB_CTRL);
      stat = (paddr == `CCA_APB_STAT);
      // one wait state so read data can come from flip-flops
      take = psel & penable & s_r.ack;
      s_nxt.ack = psel & penable & ~s_r.ack;
      if (psel && penable && !s_r.ack) begin
         s_nxt.perr = ~(ctrl | stat);
         if (ctrl) begin
            s_nxt.prdata = {5'h00, s_r.idle, s_r.grp, s_r.gen, 6'h00, 1'b0,
                            1'b0, s_r.wdata, s_r.addr};
         end else if (stat) begin
            s_nxt.prdata = {22'h0, bus.irq, s_r.busy, s_r.rbyte};
         end else begin
            s_nxt.prdata = 32'h00000000;
         end
      end
      // read answer from the device closes the pending read
      if (bus.sfr_rvalid) begin
         s_nxt.busy  = 1'b0;
         s_nxt.rbyte = bus.sfr_rdata;
      end
      // control write: store fields, fire an order unless one is pending
      if (take && pwrite && ctrl) begin
         s_nxt.addr  = pwdata[7:0];
         s_nxt.wdata = pwdata[`CCA_HC_WDATA +: 8];
         s_nxt.gen   = pwdata[`CCA_HC_GEN];
         s_nxt.grp   = pwdata[`CCA_HC_GRP];
         s_nxt.idle  = pwdata[`CCA_HC_IDLE];
         if (!s_r.busy) begin
            // flags are cleared by software writes passed through here
            s_nxt.wr = pwdata[`CCA_HC_GO_WR];
            s_nxt.rd = pwdata[`CCA_HC_GO_RD] & ~pwdata[`CCA_HC_GO_WR];
            s_nxt.busy = s_nxt.rd;
         end
      end
   end

   // single state register
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign prdata        = s_r.prdata;
   assign pready        = s_r.ack;
   assign pslverr       = s_r.ack & s_r.perr;
   assign bus.sfr_addr  = s_r.addr;
   assign bus.sfr_wdata = s_r.wdata;
   assign bus.sfr_wr    = s_r.wr;
   assign bus.sfr_rd    = s_r.rd;
   assign bus.gen       = s_r.gen;
   assign bus.grp       = s_r.grp;
   assign bus.core_idle = s_r.idle;
endmodule // cca_host
`default_nettype wire

// *** tb/cca_checker.sv ***
// concurrent checks on the sfr link between host and counter array
`include "cca_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module cca_checker (
   input wire logic       i_clock,
   input wire logic       i_rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic       sfr_wr,
   input wire logic       sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic       sfr_rvalid,
   input wire logic       irq,
   input wire logic       gen,
   input wire logic       grp
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   logic [7:0] mode_r; // shadow of the array mode register
   logic       mapped; // address decodes to a device register
   assign mapped = (sfr_addr == `CCA_SFR_CTRL) || (sfr_addr == `CCA_SFR_MODE) ||
                   (sfr_addr == `CCA_SFR_CNT_LO) || (sfr_addr == `CCA_SFR_CNT_HI) ||
                   (sfr_addr >= 8'hda && sfr_addr <= 8'hde) ||
                   (sfr_addr >= 8'hea && sfr_addr <= 8'hee) ||
                   (sfr_addr >= 8'hfa && sfr_addr <= 8'hfe);
   // shadow follows writes, so read-back can be judged without the body
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_r <= 8'h00;
      end else if (sfr_wr && sfr_addr == `CCA_SFR_MODE) begin
         mode_r <= sfr_wdata;
      end
   end
   read_answer_a: assert property (sfr_rd |=> sfr_rvalid) else $error("read not answered");
   answer_cause_a: assert property (sfr_rvalid |-> $past(sfr_rd)) else $error("stray answer");
   one_order_a: assert property (!(sfr_wr && sfr_rd)) else $error("read and write together");
   wr_pulse_a: assert property (sfr_wr |=> !sfr_wr) else $error("write strobe too long");
   rdata_hold_a: assert property (!sfr_rvalid |-> $stable(sfr_rdata)) else $error("read data moved");
   unmapped_zero_a: assert property (sfr_rd && !mapped |=> sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   mode_read_a: assert property (sfr_rd && sfr_addr == `CCA_SFR_MODE |=>
      sfr_rdata == {mode_r[7], 4'h0, mode_r[2:0]}) else $error("mode read-back wrong");
   ctrl_unused_a: assert property (sfr_rd && sfr_addr == `CCA_SFR_CTRL |=> !sfr_rdata[5])
      else $error("unused control bit set");
   irq_gate_a: assert property (irq |-> $past(gen) && $past(grp)) else $error("request while gated");
endmodule // cca_checker
`default_nettype wire

// *** tb/counter_array_capture_compare_bench.sv ***
// self-checking bench: host and counter array joined over the sfr link
`include "cca_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module counter_array_capture_compare_bench;
   logic        i_clock = 1'b0;  // 10 mhz system clock
   logic        i_rst_n = 1'b0;  // async reset, active low
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, e, irq_s, ok;
   logic        ext_cnt = 1'b0, t0 = 1'b0;  // external count and timer0 overflow
   logic [4:0]  pin_in = 5'h00, pin_out, pin_oe;
   logic        gen = 1'b0, grp = 1'b0, idle = 1'b0;  // host level fields
   logic [7:0]  d;
   logic [15:0] v;
   logic [15:0] er [5] = '{16'h1111, 16'h0000, 16'h1111, 16'h0000, 16'h0000};  // after rise
   logic [15:0] ef [5] = '{16'h1111, 16'h2222, 16'h2222, 16'h0000, 16'h0000};  // after fall
   int          error_cnt = 0, check_count = 0, i;
   cca_if bus ();
   cca_host i_cca_host (.i_clock(i_clock), .i_rst_n(i_rst_n), .bus(bus.cpu), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   cca_device i_cca_device (.i_clock(i_clock), .i_rst_n(i_rst_n), .bus(bus.dev), .i_external_count_input(ext_cnt),
      .i_timer0_ovf(t0), .i_module_pin(pin_in), .o_module_pin(pin_out), .o_module_pin_oe(pin_oe));
   cca_checker i_cca_checker (.i_clock(i_clock), .i_rst_n(i_rst_n), .sfr_addr(bus.sfr_addr),
      .sfr_wdata(bus.sfr_wdata), .sfr_wr(bus.sfr_wr), .sfr_rd(bus.sfr_rd), .sfr_rdata(bus.sfr_rdata),
      .sfr_rvalid(bus.sfr_rvalid), .irq(bus.irq), .gen(bus.gen), .grp(bus.grp));
   // free-running clock, 100 ns period
   always #50 i_clock = ~i_clock;
   // verdict and the single exit of the run
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // one comparison, four-state exact
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // apb transfer; the idle cycle at the end keeps strobes from being reassigned in one step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
                      output logic er_o);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge i_clock);
      penable <= 1'b1;
      for (n = 0; n < 50 && pready !== 1'b1; n++) @(posedge i_clock);
      if (n == 50) begin
         error_cnt++;
         end_of_test();
      end
      rd = prdata;
      er_o = pslverr;
      penable <= 1'b0;
      psel <= 1'b0;
      @(posedge i_clock);
   endtask
   // host control word: order, enables and idle level together
   task automatic hctl(input logic r, input logic w, input logic [7:0] a, input logic [7:0] wd);
      apb(1'b1, `CCA_APB_CTRL, {5'h00, idle, grp, gen, 6'h00, r, w, wd, a}, q, e);
   endtask
   task automatic sfr_w(input logic [7:0] a, input logic [7:0] wd);
      hctl(1'b0, 1'b1, a, wd);
   endtask
   // sfr read, then poll status until the byte has landed
   task automatic sfr_r(input logic [7:0] a, output logic [7:0] rd, output logic ir);
      int n;
      hctl(1'b1, 1'b0, a, 8'h00);
      for (n = 0; n < 20; n++) begin
         apb(1'b0, `CCA_APB_STAT, 32'h0, q, e);
         if (q[8] === 1'b0) break;
      end
      if (n == 20) begin
         error_cnt++;
         end_of_test();
      end
      rd = q[7:0];
      ir = q[9];
   endtask
   // low byte first so the high byte comes from the latch
   task automatic rd16(input logic [7:0] lo, input logic [7:0] hi, output logic [15:0] val);
      sfr_r(lo, val[7:0], irq_s);
      sfr_r(hi, val[15:8], irq_s);
   endtask
   task automatic set_cnt(input logic [15:0] val);
      sfr_w(`CCA_SFR_CNT_LO, val[7:0]);
      sfr_w(`CCA_SFR_CNT_HI, val[15:8]);
   endtask
   // timer0 overflow pulses, one cycle apart, then let pin registers settle
   task automatic tick(input int n);
      repeat (n) begin
         t0 <= 1'b1;
         @(posedge i_clock);
         t0 <= 1'b0;
         @(posedge i_clock);
      end
      repeat (3) @(posedge i_clock);
   endtask
   // main sequence
   initial begin
      repeat (3) @(posedge i_clock);
      i_rst_n <= 1'b1;
      @(posedge i_clock);
      apb(1'b0, 12'h008, 32'h0, q, e);
      check({31'h0, e}, 32'h1);
      check(q, 32'h0);
      sfr_r(`CCA_SFR_CTRL, d, irq_s);
      check({24'h0, d}, 32'h0);
      sfr_r(8'h80, d, irq_s);
      check({24'h0, d}, 32'h0);
      // divided clocks: 244 cycles between run on and run off
      for (i = 0; i < 2; i++) begin
         sfr_w(`CCA_SFR_MODE, (i == 0) ? 8'h02 : 8'h00);
         set_cnt(16'h0000);
         sfr_w(`CCA_SFR_CTRL, 8'h40);
         repeat (240) @(posedge i_clock);
         sfr_w(`CCA_SFR_CTRL, 8'h00);
         rd16(`CCA_SFR_CNT_LO, `CCA_SFR_CNT_HI, v);
         ok = (i == 0) ? (v > 16'd58 && v < 16'd64) : (v > 16'd17 && v < 16'd23);
         check({31'h0, ok}, 32'h1);
      end
      $display("test timebase divided done");
      sfr_w(`CCA_SFR_MODE, 8'h04);
      set_cnt(16'h0000);
      tick(3);
      rd16(`CCA_SFR_CNT_LO, `CCA_SFR_CNT_HI, v);
      check({16'h0, v}, 32'h0);
      sfr_w(`CCA_SFR_CTRL, 8'h40);
      tick(7);
      rd16(`CCA_SFR_CNT_LO, `CCA_SFR_CNT_HI, v);
      check({16'h0, v}, 32'h7);
      sfr_w(`CCA_SFR_MODE, 8'h06);
      set_cnt(16'h0000);
      repeat (5) begin
         ext_cnt <= 1'b1;
         repeat (4) @(posedge i_clock);
         ext_cnt <= 1'b0;
         repeat (4) @(posedge i_clock);
      end
      repeat (4) @(posedge i_clock);
      rd16(`CCA_SFR_CNT_LO, `CCA_SFR_CNT_HI, v);
      check({16'h0, v}, 32'h5);
      $display("test timebase events done");
      // overflow flag, interrupt gating and software clear
      sfr_w(`CCA_SFR_CTRL, 8'h00);
      sfr_w(`CCA_SFR_MODE, 8'h05);
      set_cnt(16'hfffe);
      sfr_w(`CCA_SFR_CTRL, 8'h40);
      tick(2);
      for (i = 0; i < 3; i++) begin
         gen = (i > 0);
         grp = (i > 1);
         sfr_r(`CCA_SFR_CTRL, d, irq_s);
         check({23'h0, irq_s, d}, {23'h0, i == 2, 8'hc0});
      end
      sfr_w(`CCA_SFR_CTRL, 8'h00);
      sfr_r(`CCA_SFR_CTRL, d, irq_s);
      check({23'h0, irq_s, d}, 32'h0);
      rd16(`CCA_SFR_CNT_LO, `CCA_SFR_CNT_HI, v);
      check({16'h0, v}, 32'h0);
      $display("test overflow done");
      // capture kinds on one pin sweep; module 4 holds an unlisted mode
      sfr_w(`CCA_SFR_MODE, 8'h04);
      sfr_w(8'hda, 8'h20);
      sfr_w(8'hdb, 8'h10);
      sfr_w(8'hdc, 8'h31);
      sfr_w(8'hde, 8'h38);
      set_cnt(16'h1111);
      pin_in <= 5'h1f;
      repeat (6) @(posedge i_clock);
      for (i = 0; i < 5; i++) begin
         rd16(8'hea + i[7:0], 8'hfa + i[7:0], v);
         check({16'h0, v}, {16'h0, er[i]});
      end
      set_cnt(16'h2222);
      pin_in <= 5'h00;
      repeat (6) @(posedge i_clock);
      for (i = 0; i < 5; i++) begin
         rd16(8'hea + i[7:0], 8'hfa + i[7:0], v);
         check({16'h0, v}, {16'h0, ef[i]});
      end
      sfr_r(`CCA_SFR_CTRL, d, irq_s);
      check({23'h0, irq_s, d}, 32'h107);
      sfr_w(`CCA_SFR_CTRL, 8'h03);
      sfr_r(`CCA_SFR_CTRL, d, irq_s);
      check({23'h0, irq_s, d}, 32'h003);
      $display("test capture done");
      // timer, toggle and pwm modules while the core idles
      idle = 1'b1;
      sfr_w(`CCA_SFR_CTRL, 8'h00);
      sfr_w(8'hdb, 8'h48);
      sfr_w(8'hdc, 8'h4c);
      sfr_w(8'hdd, 8'h42);
      for (i = 1; i < 4; i++) begin
         sfr_w(8'hea + i[7:0], (i == 1) ? 8'h05 : (i == 2) ? 8'h03 : 8'h02);
         sfr_w(8'hfa + i[7:0], (i == 3) ? 8'h04 : 8'h00);
      end
      set_cnt(16'h0000);
      sfr_w(`CCA_SFR_CTRL, 8'h40);
      tick(2);
      check({22'h0, pin_oe, pin_out}, {22'h0, 5'h0c, 5'h08});
      tick(1);
      check({27'h0, pin_out}, 32'h0c);
      tick(2);
      sfr_r(`CCA_SFR_CTRL, d, irq_s);
      check({24'h0, d}, 32'h46);
      tick(251);
      check({27'h0, pin_out}, 32'h04);
      sfr_r(8'hed, d, irq_s);
      check({24'h0, d}, 32'h04);
      tick(4);
      check({27'h0, pin_out}, 32'h0c);
      sfr_r(`CCA_SFR_CNT_LO, d, irq_s);
      check({24'h0, d}, 32'h04);
      tick(256);
      sfr_r(`CCA_SFR_CNT_HI, d, irq_s);
      check({24'h0, d}, 32'h01);
      rd16(`CCA_SFR_CNT_LO, `CCA_SFR_CNT_HI, v);
      check({16'h0, v}, 32'h0204);
      sfr_w(`CCA_SFR_MODE, 8'h84);
      tick(3);
      rd16(`CCA_SFR_CNT_LO, `CCA_SFR_CNT_HI, v);
      check({16'h0, v}, 32'h0204);
      $display("test compare done");
      end_of_test();
   end
endmodule // counter_array_capture_compare_bench
`default_nettype wire
